// *** core/evm_pkg.sv ***
`default_nettype none
package evm_pkg;
    // ==========================================================
    // register selection and layout
    localparam int EVM_NUM_MON = 2;
    localparam logic [0:0] EVM_SEL_MON1 = 1'h0;
    localparam logic [0:0] EVM_SEL_MON2 = 1'h1;
    localparam int EVM_CFG_W = 4;
    localparam int EVM_BIT_OV_RST = 0;
    localparam int EVM_BIT_UV_RST = 1;
    localparam int EVM_BIT_UV_SAFE = 2;
    localparam int EVM_BIT_OV_SAFE = 3;
    localparam logic [3:0] EVM_CFG_RESET = 4'h0;
    localparam logic [3:0] EVM_RSVD_READ = 4'h0;
    // ==========================================================
    // sense input synchroniser depth
    localparam int EVM_SYNC_LEN = 3;
endpackage : evm_pkg
`default_nettype wire

// *** core/evm_mon_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface evm_mon_if;
    logic [3:0] cfg;
    logic over_evt;
    logic under_evt;
    logic safe_req;
    logic reset_req;
    modport ctl (output cfg, output over_evt, output under_evt, input safe_req, input reset_req);
    modport resp (input cfg, input over_evt, input under_evt, output safe_req, output reset_req);
endinterface : evm_mon_if
`default_nettype wire

// *** core/evm_mon_resp.sv ***
`timescale 1ns/10ps
`default_nettype none
module evm_mon_resp
    import evm_pkg::*;
(
    evm_mon_if.resp mon
);
    logic rst_hit;
    logic safe_hit;
    // ==========================================================
    // event to state-request decode
    always_comb begin
        rst_hit = (mon.over_evt & mon.cfg[EVM_BIT_OV_RST])
                | (mon.under_evt & mon.cfg[EVM_BIT_UV_RST]);
        safe_hit = (mon.over_evt & mon.cfg[EVM_BIT_OV_SAFE])
                 | (mon.under_evt & mon.cfg[EVM_BIT_UV_SAFE]);
    end
    // reset path wins, so a safe request never rides along with it
    assign mon.reset_req = rst_hit;
    assign mon.safe_req = safe_hit & ~rst_hit;
endmodule // evm_mon_resp
`default_nettype wire

// *** core/evm_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module evm_top
    import evm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] nvm_under_rst_default,
    input wire logic diag_state,
    input wire logic cfg_lock,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [0:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_wr_refused,
    input wire logic ext_sense_input_1_over,
    input wire logic ext_sense_input_1_under,
    input wire logic ext_sense_input_2_over,
    input wire logic ext_sense_input_2_under,
    output logic go_safe,
    output logic go_reset
);
    // ==========================================================
    // write permission
    function automatic logic wr_allowed(input logic diag, input logic lock);
        return diag & ~lock;
    endfunction

    // power-on value; only the under-to-reset enable comes from the factory bit
    function automatic logic [3:0] cfg_init(input logic nvm_bit);
        logic [3:0] v;
        v = EVM_CFG_RESET;
        v[EVM_BIT_UV_RST] = nvm_bit;
        return v;
    endfunction

    logic [3:0] cfg_q [EVM_NUM_MON];
    logic [3:0] cfg_d [EVM_NUM_MON];
    logic [7:0] rdata_q, rdata_d;
    logic refused_q, refused_d;
    logic safe_q, safe_d, rst_q, rst_d;
    logic [3:0] raw_in;
    logic [EVM_SYNC_LEN-1:0] sync_q [4];
    logic [EVM_SYNC_LEN-1:0] sync_d [4];
    logic [3:0] lvl_q, lvl_d, evt;
    logic [EVM_NUM_MON-1:0] safe_vec, rst_vec;

    assign raw_in = {ext_sense_input_2_under, ext_sense_input_2_over,
                     ext_sense_input_1_under, ext_sense_input_1_over};

    // ==========================================================
    // sense synchronisers: level moves only when stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            // the comparators switch with no relation to clk, hence three stages
            always_comb begin
                sync_d[gi] = {sync_q[gi][EVM_SYNC_LEN-2:0], raw_in[gi]};
                lvl_d[gi] = (sync_q[gi][1] == sync_q[gi][2]) ? sync_q[gi][2] : lvl_q[gi];
            end
            // a fault counts once, on its rising edge; a held fault stays quiet
            assign evt[gi] = lvl_d[gi] & ~lvl_q[gi];
        end
    endgenerate

    // ==========================================================
    // per-monitor response decode
    generate
        for (gi = 0; gi < EVM_NUM_MON; gi++) begin : g_mon
            evm_mon_if mif ();
            assign mif.cfg = cfg_q[gi];
            assign mif.over_evt = evt[2*gi];
            assign mif.under_evt = evt[2*gi+1];
            assign safe_vec[gi] = mif.safe_req;
            assign rst_vec[gi] = mif.reset_req;
            evm_mon_resp u_resp (
                .mon(mif)
            );
        end
    endgenerate

    // ==========================================================
    // register next state
    always_comb begin
        cfg_d = cfg_q;
        refused_d = 1'b0;
        rdata_d = rdata_q;
        if (reg_wr) begin
            if (wr_allowed(diag_state, cfg_lock)) begin
                cfg_d[reg_sel] = reg_wdata[EVM_CFG_W-1:0];
            end else begin
                refused_d = 1'b1;
            end
        end
        if (reg_rd) begin
            rdata_d = {EVM_RSVD_READ, cfg_q[reg_sel]};
        end
        // one request per cycle, reset over safe across both monitors
        rst_d = |rst_vec;
        safe_d = (|safe_vec) & ~(|rst_vec);
    end

    // power-on reset only; entering the RESET state leaves these alone
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < EVM_NUM_MON; i++) begin
                cfg_q[i] <= cfg_init(nvm_under_rst_default[i]);
            end
            for (int i = 0; i < 4; i++) begin
                sync_q[i] <= '0;
            end
            rdata_q <= 8'h00;
            refused_q <= 1'b0;
            safe_q <= 1'b0;
            rst_q <= 1'b0;
            lvl_q <= 4'h0;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
            refused_q <= refused_d;
            safe_q <= safe_d;
            rst_q <= rst_d;
            lvl_q <= lvl_d;
            sync_q <= sync_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_wr_refused = refused_q;
    assign go_safe = safe_q;
    assign go_reset = rst_q;

    // ==========================================================
    // checks
    logic ov1_l, uv1_l, ov2_l, uv2_l;
    assign ov1_l = lvl_q[0];
    assign uv1_l = lvl_q[1];
    assign ov2_l = lvl_q[2];
    assign uv2_l = lvl_q[3];

    // ==========================================================
    // request path: safe checks take one event alone, so no other input can mask it; reset checks need no such guard
    a_ov_safe_path: assert property (@(posedge clk) disable iff (reset)
        evt[0] && cfg_q[0] == 4'h8 && !evt[1] && !evt[2] && !evt[3] |=> go_safe && !go_reset)
        else $error("over event with safe enable gave no safe request");
    a_ov2_safe_path: assert property (@(posedge clk) disable iff (reset)
        evt[2] && cfg_q[1] == 4'h8 && !evt[0] && !evt[1] && !evt[3] |=> go_safe && !go_reset)
        else $error("monitor 2 over event with safe enable gave no safe request");
    a_uv_safe_path: assert property (@(posedge clk) disable iff (reset)
        evt[3] && cfg_q[1] == 4'h4 && !evt[0] && !evt[1] && !evt[2] |=> go_safe)
        else $error("under event with safe enable gave no safe request");
    a_uv_reset_path: assert property (@(posedge clk) disable iff (reset)
        evt[1] && cfg_q[0][EVM_BIT_UV_RST] |=> go_reset)
        else $error("under event with reset enable gave no reset request");
    a_uv2_reset_path: assert property (@(posedge clk) disable iff (reset)
        evt[3] && cfg_q[1][EVM_BIT_UV_RST] |=> go_reset)
        else $error("monitor 2 under event with reset enable gave no reset request");
    a_ov_reset_path: assert property (@(posedge clk) disable iff (reset)
        evt[2] && cfg_q[1][EVM_BIT_OV_RST] |=> go_reset)
        else $error("over event with reset enable gave no reset request");
    a_ov1_reset_path: assert property (@(posedge clk) disable iff (reset)
        evt[0] && cfg_q[0][EVM_BIT_OV_RST] |=> go_reset)
        else $error("monitor 1 over event with reset enable gave no reset request");
    a_reset_beats_safe: assert property (@(posedge clk) disable iff (reset)
        go_reset |-> !go_safe)
        else $error("safe and reset requested together");
    a_uv_priority: assert property (@(posedge clk) disable iff (reset)
        evt[3] && cfg_q[1][EVM_BIT_UV_RST] && cfg_q[1][EVM_BIT_UV_SAFE] |=> go_reset && !go_safe)
        else $error("under reset enable lost to safe enable");
    a_ov_priority: assert property (@(posedge clk) disable iff (reset)
        evt[0] && cfg_q[0][EVM_BIT_OV_RST] && cfg_q[0][EVM_BIT_OV_SAFE] |=> go_reset && !go_safe)
        else $error("over reset enable lost to safe enable");
    a_quiet_no_enable: assert property (@(posedge clk) disable iff (reset)
        cfg_q[0] == 4'h0 && cfg_q[1] == 4'h0 |=> !go_safe && !go_reset)
        else $error("transition without any enable");
    a_quiet_lone_event: assert property (@(posedge clk) disable iff (reset)
        evt[1] && cfg_q[0] == 4'h0 && !evt[0] && !evt[2] && !evt[3] |=> !go_safe && !go_reset)
        else $error("event without enable gave a request");

    // ==========================================================
    // register port: power-on value, write gating, read-back; then the sense filter stage agreement
    a_nvm_default: assert property (@(posedge clk)
        reset |=> cfg_q[0] == {2'h0, $past(nvm_under_rst_default[0]), 1'h0}
            && cfg_q[1] == {2'h0, $past(nvm_under_rst_default[1]), 1'h0})
        else $error("power-on value wrong");
    a_locked_hold: assert property (@(posedge clk) disable iff (reset)
        reg_wr && !wr_allowed(diag_state, cfg_lock) |=> cfg_q[1] == $past(cfg_q[1]) && reg_wr_refused)
        else $error("locked write changed monitor 2 config");
    a_mon1_locked_hold: assert property (@(posedge clk) disable iff (reset)
        reg_wr && !wr_allowed(diag_state, cfg_lock) |=> cfg_q[0] == $past(cfg_q[0]) && reg_wr_refused)
        else $error("locked write changed monitor 1 config");
    a_refused_cause: assert property (@(posedge clk) disable iff (reset)
        reg_wr_refused |-> $past(reg_wr) && !wr_allowed($past(diag_state), $past(cfg_lock)))
        else $error("refusal without a blocked write");
    a_write_lands: assert property (@(posedge clk) disable iff (reset)
        reg_wr && diag_state && !cfg_lock && reg_sel == EVM_SEL_MON1 |=> cfg_q[0] == $past(reg_wdata[3:0]))
        else $error("allowed write to monitor 1 not stored");
    a_mon2_write_lands: assert property (@(posedge clk) disable iff (reset)
        reg_wr && diag_state && !cfg_lock && reg_sel == EVM_SEL_MON2 |=> cfg_q[1] == $past(reg_wdata[3:0]))
        else $error("allowed write to monitor 2 not stored");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
        reg_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    a_read_data: assert property (@(posedge clk) disable iff (reset)
        reg_rd && reg_sel == EVM_SEL_MON1 |=> reg_rdata == {4'h0, $past(cfg_q[0])})
        else $error("read of monitor 1 config returned wrong data");
    a_cfg_kept: assert property (@(posedge clk) disable iff (reset)
        !reg_wr |=> cfg_q[0] == $past(cfg_q[0]) && cfg_q[1] == $past(cfg_q[1]))
        else $error("config changed without a write");
    a_sense_filter: assert property (@(posedge clk) disable iff (reset)
        $rose(ov1_l) |-> $past(sync_q[0][2]) && $past(sync_q[0][1]))
        else $error("level moved without stage agreement");

    // ==========================================================
    // scenario covers
    c_safe_seen: cover property (@(posedge clk) disable iff (reset) go_safe);
    c_reset_seen: cover property (@(posedge clk) disable iff (reset) go_reset);
    c_refused_write: cover property (@(posedge clk) disable iff (reset) reg_wr_refused);
    c_under2_event: cover property (@(posedge clk) disable iff (reset) $rose(uv2_l) && !ov2_l && !uv1_l);
    c_uv_priority_hit: cover property (@(posedge clk) disable iff (reset)
        evt[1] && cfg_q[0][EVM_BIT_UV_RST] && cfg_q[0][EVM_BIT_UV_SAFE]);
endmodule // evm_top
`default_nettype wire

// *** sim/evm_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// host stand-in: one strobe per register command
module evm_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [0:0] reg_sel,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_sel = 1'h0;
        reg_wdata = 8'h00;
    end
    // set up on falling edge, held across the taking edge; data inverted after
    task automatic access(input logic wr, input logic [0:0] sel, input logic [7:0] d);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_sel = sel;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule // evm_host
`default_nettype wire

// *** sim/ext_vmon_fault_response_cfg_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module ext_vmon_fault_response_cfg_bench;
    import evm_pkg::*;
    logic clk = 1'b0, reset = 1'b1, diag = 1'b0, lock = 1'b0, rd_t = 1'b0, rst, sf;
    logic [1:0] nvm = 2'h0;
    logic [3:0] sense = 4'h0;
    logic [15:0] lf = 16'h469c;
    logic wr, rd, refused, go_safe, go_reset;
    logic [0:0] sel;
    logic [7:0] wdata, rdata;
    logic [10:0] q[$];
    logic [10:0] want, got;
    int err_total = 0, n_compared = 0, cyc = 0;
    always #2.5 clk = ~clk;
    evm_host host_u (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_sel(sel), .reg_wdata(wdata));
    evm_top dut_u (.clk(clk), .reset(reset), .nvm_under_rst_default(nvm), .diag_state(diag),
        .cfg_lock(lock), .reg_wr(wr), .reg_rd(rd), .reg_sel(sel), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_wr_refused(refused), .ext_sense_input_1_over(sense[0]),
        .ext_sense_input_1_under(sense[1]), .ext_sense_input_2_over(sense[2]),
        .ext_sense_input_2_under(sense[3]), .go_safe(go_safe), .go_reset(go_reset));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========
    // watcher: each result pops the oldest note; read data only counts after a read
    always @(posedge clk) rd_t <= rd;
    always @(negedge clk) begin
        if (!reset && (go_safe !== 1'b0 || go_reset !== 1'b0 || refused !== 1'b0 || rd_t)) begin
            got = {go_safe, go_reset, refused, rd_t ? rdata : 8'h00};
            want = (q.size() == 0) ? 11'h7ff : q.pop_front();
            n_compared++;
            if (got !== want) begin
                err_total++;
                $display("wrong value at %0t got %h expected %h", $time, got, want);
            end
        end
    end
    // hang guard, well above the ~1100 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            complete_run();
        end
    end
    // ==========
    // main sequence
    initial begin
        nvm = lf[2:1];
        repeat (2) @(negedge clk);
        reset = 1'b0;
        for (int m = 0; m < 2; m++) begin
            q.push_back({9'h000, nvm[m], 1'b0});
            host_u.access(1'b0, m[0], 8'h00);
        end
        // refused writes: outside diagnostic, then locked
        for (int k = 0; k < 2; k++) begin
            diag = k[0];
            lock = k[0];
            for (int m = 0; m < 2; m++) begin
                q.push_back(11'h100);
                host_u.access(1'b1, m[0], 8'hff);
                q.push_back({9'h000, nvm[m], 1'b0});
                host_u.access(1'b0, m[0], 8'h00);
            end
        end
        lock = 1'b0;
        // every enable pattern against both events on both monitors
        for (int c = 0; c < 16; c++) begin
            lf = lfsr(lf);
            for (int m = 0; m < 2; m++) begin
                host_u.access(1'b1, m[0], {lf[7:4], c[3:0]});
                for (int u = 0; u < 2; u++) begin
                    rst = u ? c[1] : c[0];
                    sf = !rst && (u ? c[2] : c[3]);
                    if (rst || sf) q.push_back({sf, rst, 9'h000});
                    sense[m * 2 + u] = 1'b1;
                    repeat (9) @(negedge clk);
                    sense[m * 2 + u] = 1'b0;
                    repeat (6) @(negedge clk);
                end
                q.push_back({7'h00, c[3:0]});
                host_u.access(1'b0, m[0], 8'h00);
            end
        end
        // second power-on reset mid-run: enables go back to the factory bits
        repeat (4) @(negedge clk);
        lf = lfsr(lf);
        reset = 1'b1;
        nvm = lf[1:0];
        repeat (2) @(negedge clk);
        reset = 1'b0;
        for (int m = 0; m < 2; m++) begin
            q.push_back({9'h000, nvm[m], 1'b0});
            host_u.access(1'b0, m[0], 8'h00);
        end
        repeat (10) @(negedge clk);
        // notes left over mean an expected result never showed up
        if (q.size() != 0) begin
            err_total++;
            $display("wrong value at %0t got %h expected %h", $time, q.size(), 0);
        end
        complete_run();
    end
endmodule // ext_vmon_fault_response_cfg_bench
`default_nettype wire
